// File: verilog/eic_pkg.sv
// Constants shared by the endpoint interrupt and configuration port logic.
// Assumes one clock domain and Dword-addressed configuration registers.
package eic_pkg;
  // Dword indices of the implemented configuration registers
  localparam logic [9:0] DW_CMD_STATUS = 10'h001;
  localparam logic [9:0] DW_T1_IO_BASE = 10'h007;
  localparam logic [9:0] DW_MSI_CTRL = 10'h012;
  localparam logic [9:0] DW_MSI_ADDR_LO = 10'h013;
  localparam logic [9:0] DW_MSI_ADDR_HI = 10'h014;
  localparam logic [9:0] DW_MSI_DATA = 10'h015;
  localparam logic [9:0] DW_MSI_MASK = 10'h016;
  localparam logic [9:0] DW_MSIX_CTRL = 10'h01C;
  localparam logic [7:0] FUNC_ZERO = 8'h00;

  // Field positions
  localparam int CMD_INTX_DIS_BIT = 10;
  localparam int STS_INT_BIT = 19;
  localparam int MSI_EN_BIT = 16;
  localparam int MSI_MMC_LSB = 17;
  localparam int MSI_MME_LSB = 20;
  localparam int MSI_64_CAP_BIT = 23;
  localparam int MSIX_EN_BIT = 31;

  // Reset values and the largest supported MSI_MMC value
  localparam logic [2:0] CMD_RESET = 3'h0;
  localparam logic [2:0] MME_RESET = 3'h0;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [3:0] T1_RO_RESET = 4'h1;
  localparam logic [2:0] MMC_MAX = 3'h5;

  // Outgoing message kinds
  typedef enum logic [1:0] {
    EIC_MSG_ASSERT_INTA = 2'h0,
    EIC_MSG_DEASSERT_INTA = 2'h1,
    EIC_MSG_MWR32 = 2'h2,
    EIC_MSG_MWR64 = 2'h3
  } eic_msg_t;

  // Interrupt sequencer states, Gray along the legacy path from EIC_ST_IDLE to EIC_ST_LEG_DONE
  typedef enum logic [2:0] {
    EIC_ST_IDLE = 3'b000,
    EIC_ST_LEG_ASSERT = 3'b001,
    EIC_ST_LEG_HOLD = 3'b011,
    EIC_ST_LEG_DEASSERT = 3'b010,
    EIC_ST_LEG_DONE = 3'b110,
    EIC_ST_MSI_SEND = 3'b100
  } eic_state_t;
endpackage

// File: verilog/eic_endpoint_irq.sv
// Endpoint interrupt request logic and configuration management port.
// Overview of operation
// - Mode outputs follow the MSI Enable and MSI-X Enable bits; endpoint only.
// - Both enables low: legacy mode, only INTx assert and deassert messages.
// - MSI on, MSI-X off: only MSI interrupts, each a memory write.
// - Both enables on: interface stays active and sends MSI writes on request.
// - MSI, MSI-X enable and interrupt disable bits change only by root writes.
// - Legacy requests blocked while command bit 10 set; flags show the state.
// - Legacy request with pending gets accepted pulse, then Assert_INTA is sent.
// - After request drops, Deassert_INTA is sent and accepted pulses again.
// - MSI vector request gets accepted pulse, then one MSI write is sent.
// - MSI address from address fields, payload from message data field.
// - MSI uses 32-bit addressing unless upper address is non-zero.
// - Replaceable data bits are lesser of capable and enabled; higher bits masked.
// - Read data valid only in the cycle with done asserted.
// - Write with data and lane selects completes with a done strobe.
// - Root port override forces writes into read-only Type-1 fields.
// Assumes all inputs come from logic on i_core_clk; root writes arrive as one-cycle strobes.
`timescale 1ns/1ns
`default_nettype none

module eic_endpoint_irq #(
  parameter logic [2:0] MSI_MMC = 3'h5,
  parameter bit ROOT_PORT = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_legacy_irq_request,
  input wire logic i_legacy_irq_pending,
  input wire logic i_msi_request_valid,
  input wire logic [4:0] i_msi_vector_request,
  input wire logic [17:0] i_cfg_space_addr,
  input wire logic [31:0] i_cfg_space_wdata,
  input wire logic [3:0] i_cfg_space_lane_sel,
  input wire logic i_cfg_space_wr,
  input wire logic i_cfg_space_rd,
  input wire logic i_type1_ro_override,
  input wire logic i_rc_cfg_wr,
  input wire logic [9:0] i_rc_cfg_addr,
  input wire logic [31:0] i_rc_cfg_wdata,
  input wire logic [3:0] i_rc_cfg_lane_sel,
  input wire logic i_msg_ready,
  output logic o_msi_mode_on,
  output logic o_msix_mode_on,
  output logic [2:0] o_msi_vectors_granted,
  output logic [1:0] o_function_state_flags,
  output logic o_legacy_irq_accepted,
  output logic o_msi_accepted,
  output logic o_msg_valid,
  output logic [1:0] o_msg_kind,
  output logic [63:0] o_msg_addr,
  output logic [31:0] o_msg_data,
  output logic [31:0] o_cfg_space_rdata,
  output logic o_cfg_space_done
);

  // Elaboration-time refusal of capability values the vector logic cannot serve
  if (MSI_MMC > eic_pkg::MMC_MAX) begin : g_mmc_check
    $error("MSI_MMC above 5 is not supported");
  end

  // Byte-lane merge restricted to bits that a writer may touch
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] lanes,
                                             input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}} & wmask;
    lane_merge = (old_val & ~m) | (new_val & m);
  endfunction

  function automatic logic [2:0] min3(input logic [2:0] a, input logic [2:0] b);
    min3 = (a < b) ? a : b;
  endfunction

  // Registers of configuration space
  logic [2:0] cmd_low_reg;
  logic intx_dis_reg;
  logic msi_en_reg;
  logic [2:0] mme_reg;
  logic [31:0] msi_addr_lo_reg;
  logic [31:0] msi_addr_hi_reg;
  logic [15:0] msi_data_reg;
  logic [31:0] msi_mask_reg;
  logic msix_en_reg;
  logic [3:0] t1_base_ro_reg;
  logic [3:0] t1_base_rw_reg;
  logic [3:0] t1_lim_ro_reg;
  logic [3:0] t1_lim_rw_reg;
  logic int_status_reg;

  // Current contents of each register as read back
  logic [31:0] rd_cmd;
  logic [31:0] rd_msi_ctrl;
  logic [31:0] rd_t1;
  assign rd_cmd = {12'h000, int_status_reg, 8'h00, intx_dis_reg, 7'h00, cmd_low_reg};
  assign rd_msi_ctrl = {8'h00, 1'b1, mme_reg, MSI_MMC, msi_en_reg, 16'h0005};
  assign rd_t1 = {16'h0000, t1_lim_rw_reg, t1_lim_ro_reg, t1_base_rw_reg, t1_base_ro_reg};

  function automatic logic [31:0] reg_read(input logic [9:0] dw,
                                           input logic [31:0] cmd_v,
                                           input logic [31:0] ctrl_v,
                                           input logic [31:0] t1_v,
                                           input logic [31:0] lo_v,
                                           input logic [31:0] hi_v,
                                           input logic [15:0] data_v,
                                           input logic [31:0] mask_v,
                                           input logic msix_v);
    case (dw)
      eic_pkg::DW_CMD_STATUS: reg_read = cmd_v;
      eic_pkg::DW_T1_IO_BASE: reg_read = ROOT_PORT ? t1_v : eic_pkg::ZERO32;
      eic_pkg::DW_MSI_CTRL: reg_read = ctrl_v;
      eic_pkg::DW_MSI_ADDR_LO: reg_read = lo_v;
      eic_pkg::DW_MSI_ADDR_HI: reg_read = hi_v;
      eic_pkg::DW_MSI_DATA: reg_read = {16'h0000, data_v};
      eic_pkg::DW_MSI_MASK: reg_read = mask_v;
      eic_pkg::DW_MSIX_CTRL: reg_read = {msix_v, 31'h0000_0011};
      default: reg_read = eic_pkg::ZERO32;
    endcase
  endfunction

  // User configuration port: one access per strobe, done in the next cycle
  logic user_hit;
  logic user_wr_go;
  logic user_rd_go;
  logic [9:0] user_dw;
  assign user_dw = i_cfg_space_addr[9:0];
  assign user_hit = (i_cfg_space_addr[17:10] == eic_pkg::FUNC_ZERO);
  assign user_wr_go = i_cfg_space_wr & ~o_cfg_space_done;
  assign user_rd_go = i_cfg_space_rd & ~i_cfg_space_wr & ~o_cfg_space_done;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_cfg_space_done <= 1'b0;
    end else begin
      o_cfg_space_done <= user_wr_go | user_rd_go;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_cfg_space_rdata <= eic_pkg::ZERO32;
    end else if (user_rd_go && user_hit) begin
      o_cfg_space_rdata <= reg_read(user_dw, rd_cmd, rd_msi_ctrl, rd_t1, msi_addr_lo_reg,
                                    msi_addr_hi_reg, msi_data_reg, msi_mask_reg,
                                    msix_en_reg);
    end else begin
      o_cfg_space_rdata <= eic_pkg::ZERO32;
    end
  end

  // Write paths: user port and root complex, root applied last
  logic uw;
  logic rw;
  assign uw = user_wr_go & user_hit;
  assign rw = i_rc_cfg_wr;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cmd_low_reg <= eic_pkg::CMD_RESET;
      intx_dis_reg <= 1'b0;
      msi_en_reg <= 1'b0;
      mme_reg <= eic_pkg::MME_RESET;
      msix_en_reg <= 1'b0;
    end else begin
      if (uw && user_dw == eic_pkg::DW_CMD_STATUS && i_cfg_space_lane_sel[0]) begin
        cmd_low_reg <= i_cfg_space_wdata[2:0];
      end
      if (rw && i_rc_cfg_addr == eic_pkg::DW_CMD_STATUS) begin
        if (i_rc_cfg_lane_sel[0]) begin
          cmd_low_reg <= i_rc_cfg_wdata[2:0];
        end
        if (i_rc_cfg_lane_sel[1]) begin
          intx_dis_reg <= i_rc_cfg_wdata[eic_pkg::CMD_INTX_DIS_BIT];
        end
      end
      if (rw && i_rc_cfg_addr == eic_pkg::DW_MSI_CTRL && i_rc_cfg_lane_sel[2]) begin
        msi_en_reg <= i_rc_cfg_wdata[eic_pkg::MSI_EN_BIT];
        mme_reg <= min3(i_rc_cfg_wdata[eic_pkg::MSI_MME_LSB +: 3], MSI_MMC);
      end
      if (rw && i_rc_cfg_addr == eic_pkg::DW_MSIX_CTRL && i_rc_cfg_lane_sel[3]) begin
        msix_en_reg <= i_rc_cfg_wdata[eic_pkg::MSIX_EN_BIT];
      end
    end
  end

  // MSI address, data and mask fields, writable by both sources
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      msi_addr_lo_reg <= eic_pkg::ZERO32;
      msi_addr_hi_reg <= eic_pkg::ZERO32;
      msi_data_reg <= 16'h0000;
      msi_mask_reg <= eic_pkg::ZERO32;
    end else begin
      if (uw && user_dw == eic_pkg::DW_MSI_ADDR_LO) begin
        msi_addr_lo_reg <= lane_merge(msi_addr_lo_reg, i_cfg_space_wdata,
                                      i_cfg_space_lane_sel, 32'hFFFF_FFFC);
      end
      if (uw && user_dw == eic_pkg::DW_MSI_ADDR_HI) begin
        msi_addr_hi_reg <= lane_merge(msi_addr_hi_reg, i_cfg_space_wdata,
                                      i_cfg_space_lane_sel, 32'hFFFF_FFFF);
      end
      if (uw && user_dw == eic_pkg::DW_MSI_DATA) begin
        msi_data_reg <= 16'(lane_merge({16'h0000, msi_data_reg}, i_cfg_space_wdata,
                                       i_cfg_space_lane_sel, 32'h0000_FFFF));
      end
      if (uw && user_dw == eic_pkg::DW_MSI_MASK) begin
        msi_mask_reg <= lane_merge(msi_mask_reg, i_cfg_space_wdata,
                                   i_cfg_space_lane_sel, 32'hFFFF_FFFF);
      end
      if (rw && i_rc_cfg_addr == eic_pkg::DW_MSI_ADDR_LO) begin
        msi_addr_lo_reg <= lane_merge(msi_addr_lo_reg, i_rc_cfg_wdata,
                                      i_rc_cfg_lane_sel, 32'hFFFF_FFFC);
      end
      if (rw && i_rc_cfg_addr == eic_pkg::DW_MSI_ADDR_HI) begin
        msi_addr_hi_reg <= lane_merge(msi_addr_hi_reg, i_rc_cfg_wdata,
                                      i_rc_cfg_lane_sel, 32'hFFFF_FFFF);
      end
      if (rw && i_rc_cfg_addr == eic_pkg::DW_MSI_DATA) begin
        msi_data_reg <= 16'(lane_merge({16'h0000, msi_data_reg}, i_rc_cfg_wdata,
                                       i_rc_cfg_lane_sel, 32'h0000_FFFF));
      end
      if (rw && i_rc_cfg_addr == eic_pkg::DW_MSI_MASK) begin
        msi_mask_reg <= lane_merge(msi_mask_reg, i_rc_cfg_wdata,
                                   i_rc_cfg_lane_sel, 32'hFFFF_FFFF);
      end
    end
  end

  // Type-1 I/O base and limit; low nibbles read-only unless overridden in root port mode
  logic t1_wr;
  logic t1_force;
  assign t1_wr = ROOT_PORT && uw && user_dw == eic_pkg::DW_T1_IO_BASE;
  assign t1_force = t1_wr & i_type1_ro_override;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      t1_base_ro_reg <= eic_pkg::T1_RO_RESET;
      t1_lim_ro_reg <= eic_pkg::T1_RO_RESET;
      t1_base_rw_reg <= 4'h0;
      t1_lim_rw_reg <= 4'h0;
    end else begin
      if (t1_wr && i_cfg_space_lane_sel[0]) begin
        t1_base_rw_reg <= i_cfg_space_wdata[7:4];
      end
      if (t1_wr && i_cfg_space_lane_sel[1]) begin
        t1_lim_rw_reg <= i_cfg_space_wdata[15:12];
      end
      if (t1_force && i_cfg_space_lane_sel[0]) begin
        t1_base_ro_reg <= i_cfg_space_wdata[3:0];
      end
      if (t1_force && i_cfg_space_lane_sel[1]) begin
        t1_lim_ro_reg <= i_cfg_space_wdata[11:8];
      end
    end
  end

  // Status flags toward user logic
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_msi_mode_on <= 1'b0;
      o_msix_mode_on <= 1'b0;
      o_msi_vectors_granted <= eic_pkg::MME_RESET;
      o_function_state_flags <= 2'h0;
    end else begin
      o_msi_mode_on <= msi_en_reg;
      o_msix_mode_on <= msix_en_reg;
      o_msi_vectors_granted <= mme_reg;
      o_function_state_flags <= {int_status_reg, intx_dis_reg};
    end
  end

  // Interrupt sequencer; MSI-X is left to user logic on the transmit stream
  eic_pkg::eic_state_t state_reg;
  logic leg_ok;
  logic msi_ok;
  logic msg_take;
  logic [2:0] vec_bits;
  logic [15:0] vec_mask;
  logic [15:0] msi_payload;
  assign leg_ok = ~msi_en_reg & ~msix_en_reg & ~intx_dis_reg;
  assign msi_ok = msi_en_reg;
  assign msg_take = o_msg_valid & i_msg_ready;
  assign vec_bits = min3(MSI_MMC, mme_reg);
  assign vec_mask = 16'((32'h1 << vec_bits) - 32'h1);
  assign msi_payload = (msi_data_reg & ~vec_mask)
                     | ({11'h000, i_msi_vector_request} & vec_mask);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg <= eic_pkg::EIC_ST_IDLE;
      o_legacy_irq_accepted <= 1'b0;
      o_msi_accepted <= 1'b0;
      o_msg_valid <= 1'b0;
      o_msg_kind <= eic_pkg::EIC_MSG_ASSERT_INTA;
      o_msg_addr <= 64'h0000_0000_0000_0000;
      o_msg_data <= eic_pkg::ZERO32;
    end else begin
      o_legacy_irq_accepted <= 1'b0;
      o_msi_accepted <= 1'b0;
      if (msg_take) begin
        o_msg_valid <= 1'b0;
      end
      case (state_reg)
        eic_pkg::EIC_ST_IDLE: begin
          if (i_msi_request_valid && msi_ok) begin
            o_msi_accepted <= 1'b1;
            o_msg_valid <= 1'b1;
            o_msg_data <= {16'h0000, msi_payload};
            if (msi_addr_hi_reg != eic_pkg::ZERO32) begin
              o_msg_kind <= eic_pkg::EIC_MSG_MWR64;
            end else begin
              o_msg_kind <= eic_pkg::EIC_MSG_MWR32;
            end
            o_msg_addr <= {msi_addr_hi_reg, msi_addr_lo_reg};
            state_reg <= eic_pkg::EIC_ST_MSI_SEND;
          end else if (i_legacy_irq_request && i_legacy_irq_pending && leg_ok) begin
            o_legacy_irq_accepted <= 1'b1;
            o_msg_valid <= 1'b1;
            o_msg_kind <= eic_pkg::EIC_MSG_ASSERT_INTA;
            o_msg_addr <= 64'h0000_0000_0000_0000;
            o_msg_data <= eic_pkg::ZERO32;
            state_reg <= eic_pkg::EIC_ST_LEG_ASSERT;
          end
        end
        eic_pkg::EIC_ST_LEG_ASSERT: begin
          if (msg_take) begin
            state_reg <= eic_pkg::EIC_ST_LEG_HOLD;
          end
        end
        eic_pkg::EIC_ST_LEG_HOLD: begin
          if (!i_legacy_irq_request) begin
            o_msg_valid <= 1'b1;
            o_msg_kind <= eic_pkg::EIC_MSG_DEASSERT_INTA;
            state_reg <= eic_pkg::EIC_ST_LEG_DEASSERT;
          end
        end
        eic_pkg::EIC_ST_LEG_DEASSERT: begin
          if (msg_take) begin
            o_legacy_irq_accepted <= 1'b1;
            state_reg <= eic_pkg::EIC_ST_LEG_DONE;
          end
        end
        eic_pkg::EIC_ST_LEG_DONE: begin
          state_reg <= eic_pkg::EIC_ST_IDLE;
        end
        eic_pkg::EIC_ST_MSI_SEND: begin
          if (msg_take) begin
            state_reg <= eic_pkg::EIC_ST_IDLE;
          end
        end
        default: begin
          state_reg <= eic_pkg::EIC_ST_IDLE;
        end
      endcase
    end
  end

  // Interrupt status bit reflects an asserted INTx while user keeps pending high
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      int_status_reg <= 1'b0;
    end else begin
      int_status_reg <= i_legacy_irq_pending
                      & (state_reg == eic_pkg::EIC_ST_LEG_HOLD
                         || state_reg == eic_pkg::EIC_ST_LEG_DEASSERT);
    end
  end

endmodule

`default_nettype wire

// File: test/eic_endpoint_irq_assertions.sv
// Concurrent checks on the endpoint interrupt and configuration port.
// Sees only top-level ports; bound to every eic_endpoint_irq instance.
`timescale 1ns/1ns
`default_nettype none
module eic_endpoint_irq_chk (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_msg_ready,
  input wire logic i_cfg_space_wr,
  input wire logic i_cfg_space_rd,
  input wire logic [17:0] i_cfg_space_addr,
  input wire logic i_rc_cfg_wr,
  input wire logic [9:0] i_rc_cfg_addr,
  input wire logic [31:0] i_rc_cfg_wdata,
  input wire logic [3:0] i_rc_cfg_lane_sel,
  input wire logic o_msi_mode_on,
  input wire logic [1:0] o_function_state_flags,
  input wire logic o_legacy_irq_accepted,
  input wire logic o_msi_accepted,
  input wire logic o_msg_valid,
  input wire logic [1:0] o_msg_kind,
  input wire logic [63:0] o_msg_addr,
  input wire logic [31:0] o_cfg_space_rdata,
  input wire logic o_cfg_space_done
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_cfg_take;
    (i_cfg_space_wr || i_cfg_space_rd) && !o_cfg_space_done;
  endsequence
  sequence s_deassert_sent;
    o_msg_valid && i_msg_ready && o_msg_kind == eic_pkg::EIC_MSG_DEASSERT_INTA;
  endsequence
  property p_cfg_done;
    s_cfg_take |=> o_cfg_space_done ##1 !o_cfg_space_done;
  endproperty
  a_cfg_done: assert property (p_cfg_done) else $error("config done missing");
  property p_rdata_qual;
    !o_cfg_space_done |-> o_cfg_space_rdata == 32'h0000_0000;
  endproperty
  a_rdata_qual: assert property (p_rdata_qual) else $error("read data outside done");
  property p_leg_assert;
    o_legacy_irq_accepted && o_msg_valid |->
      o_msg_kind == eic_pkg::EIC_MSG_ASSERT_INTA && !o_function_state_flags[0];
  endproperty
  a_leg_assert: assert property (p_leg_assert) else $error("bad legacy assert");
  property p_leg_second;
    s_deassert_sent |=> o_legacy_irq_accepted && !o_msg_valid;
  endproperty
  a_leg_second: assert property (p_leg_second) else $error("no second accept");
  property p_msi_mwr;
    o_msi_accepted |-> o_msg_valid && o_msg_kind[1];
  endproperty
  a_msi_mwr: assert property (p_msi_mwr) else $error("MSI not a memory write");
  property p_msi_width;
    o_msi_accepted |-> o_msg_kind[0] == (o_msg_addr[63:32] != 32'h0000_0000);
  endproperty
  a_msi_width: assert property (p_msi_width) else $error("MSI address width");
  property p_msg_hold;
    o_msg_valid && !i_msg_ready |=> o_msg_valid && $stable(o_msg_kind) && $stable(o_msg_addr);
  endproperty
  a_msg_hold: assert property (p_msg_hold) else $error("message dropped");
  property p_mode_follow;
    i_rc_cfg_wr && i_rc_cfg_addr == eic_pkg::DW_MSI_CTRL && i_rc_cfg_lane_sel[2] |->
      ##2 o_msi_mode_on == $past(i_rc_cfg_wdata[16], 2);
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("MSI mode not followed");
  property p_user_no_en;
    s_cfg_take ##0 i_cfg_space_wr && i_cfg_space_addr[9:0] == eic_pkg::DW_MSI_CTRL &&
      !i_rc_cfg_wr |=> ##1 $stable(o_msi_mode_on);
  endproperty
  a_user_no_en: assert property (p_user_no_en) else $error("user changed enable");
endmodule
bind eic_endpoint_irq eic_endpoint_irq_chk i_chk (.i_core_clk, .i_rst, .i_msg_ready,
  .i_cfg_space_wr, .i_cfg_space_rd, .i_cfg_space_addr, .i_rc_cfg_wr, .i_rc_cfg_addr,
  .i_rc_cfg_wdata, .i_rc_cfg_lane_sel, .o_msi_mode_on, .o_function_state_flags,
  .o_legacy_irq_accepted, .o_msi_accepted, .o_msg_valid, .o_msg_kind, .o_msg_addr,
  .o_cfg_space_rdata, .o_cfg_space_done);
`default_nettype wire

// File: test/eic_msg_sink.sv
// Link-side sink that takes interrupt messages from the block.
// Runs on the block clock; slow mode stalls three cycles in four.
`timescale 1ns/1ns
`default_nettype none
module eic_msg_sink (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_msg_valid,
  input wire logic [1:0] i_msg_kind,
  output logic o_msg_ready,
  output logic [1:0] o_last_kind,
  output logic [7:0] o_count
);
  logic [1:0] gap_reg;
  assign o_msg_ready = !i_slow || (gap_reg == 2'h3);
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      gap_reg <= 2'h0;
      o_last_kind <= 2'h0;
      o_count <= 8'h00;
    end else begin
      gap_reg <= gap_reg + 2'h1;
      if (i_msg_valid && o_msg_ready) begin
        o_last_kind <= i_msg_kind;
        o_count <= o_count + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the endpoint interrupt and configuration port.
// Drives the user, root-complex and config ports; a sink takes messages.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst = 1'b1, slow = 1'b0;
  logic leg_req = 1'b0, leg_pend = 1'b0, msi_v = 1'b0, c_wr = 1'b0, c_rd = 1'b0, rc_wr = 1'b0;
  logic [4:0] msi_vec = 5'h00;
  logic [17:0] c_addr = 18'h0_0000;
  logic [31:0] c_wdata = 32'h0000_0000, rc_wdata = 32'h0000_0000;
  logic [3:0] c_lanes = 4'h0, rc_lanes = 4'h0;
  logic [9:0] rc_addr = 10'h000;
  logic t1_ovr = 1'b0;
  logic msi_on, msix_on, leg_acc, msi_acc, m_valid, m_ready, c_done;
  logic [2:0] granted;
  logic [1:0] flags, m_kind, last_kind;
  logic [63:0] m_addr;
  logic [31:0] m_data, c_rdata, rd_q;
  logic [7:0] m_count;
  int bad_count = 0, n_tests = 0;
  always #4 clk = ~clk;
  eic_endpoint_irq #(.MSI_MMC(3'h3), .ROOT_PORT(1'b0)) i_dut (.i_core_clk(clk), .i_rst(rst),
    .i_legacy_irq_request(leg_req), .i_legacy_irq_pending(leg_pend),
    .i_msi_request_valid(msi_v), .i_msi_vector_request(msi_vec), .i_cfg_space_addr(c_addr),
    .i_cfg_space_wdata(c_wdata), .i_cfg_space_lane_sel(c_lanes), .i_cfg_space_wr(c_wr),
    .i_cfg_space_rd(c_rd), .i_type1_ro_override(t1_ovr), .i_rc_cfg_wr(rc_wr),
    .i_rc_cfg_addr(rc_addr), .i_rc_cfg_wdata(rc_wdata), .i_rc_cfg_lane_sel(rc_lanes),
    .i_msg_ready(m_ready), .o_msi_mode_on(msi_on), .o_msix_mode_on(msix_on),
    .o_msi_vectors_granted(granted), .o_function_state_flags(flags),
    .o_legacy_irq_accepted(leg_acc), .o_msi_accepted(msi_acc), .o_msg_valid(m_valid),
    .o_msg_kind(m_kind), .o_msg_addr(m_addr), .o_msg_data(m_data),
    .o_cfg_space_rdata(c_rdata), .o_cfg_space_done(c_done));
  eic_msg_sink i_sink (.i_core_clk(clk), .i_rst(rst), .i_slow(slow), .i_msg_valid(m_valid),
    .i_msg_kind(m_kind), .o_msg_ready(m_ready), .o_last_kind(last_kind), .o_count(m_count));
  task automatic results();
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_is(ref logic s, input logic v);
    for (int k = 0; k < 64 && s !== v; k++) begin
      @(posedge clk);
      #1;
    end
    if (s !== v) begin
      bad_count++;
      $display("[FAIL] %0t wait ran out", $time);
      results();
    end
  endtask
  task automatic cfg(input logic w, input logic [17:0] a, input logic [31:0] d,
                     input logic [3:0] l);
    @(posedge clk);
    c_wr <= w;
    c_rd <= !w;
    c_addr <= a;
    c_wdata <= d;
    c_lanes <= l;
    #1;
    wait_is(c_done, 1'b1);
    rd_q = c_rdata;
    @(posedge clk);
    c_wr <= 1'b0;
    c_rd <= 1'b0;
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rd_q, exp);
  endtask
  task automatic rc(input logic [9:0] a, input logic [31:0] d, input logic [3:0] l);
    @(posedge clk);
    rc_wr <= 1'b1;
    rc_addr <= a;
    rc_wdata <= d;
    rc_lanes <= l;
    @(posedge clk);
    rc_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic msi(input logic [4:0] v, input logic [1:0] k, input logic [63:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    msi_v <= 1'b1;
    msi_vec <= v;
    #1;
    wait_is(msi_acc, 1'b1);
    chk({m_valid, m_kind}, {1'b1, k});
    chk(m_addr, a);
    chk(m_data, d);
    @(posedge clk);
    msi_v <= 1'b0;
    #1;
    wait_is(m_valid, 1'b0);
  endtask
  task automatic legacy(input logic take);
    logic [7:0] c0;
    c0 = m_count;
    @(posedge clk);
    leg_req <= 1'b1;
    leg_pend <= 1'b1;
    #1;
    if (take) begin
      wait_is(leg_acc, 1'b1);
      chk({m_valid, m_kind}, {1'b1, 2'h0});
      @(posedge clk);
      leg_req <= 1'b0;
      #1;
      wait_is(leg_acc, 1'b1);
      chk({last_kind, m_count - c0, flags[1]}, {2'h1, 8'h02, 1'b1});
    end else begin
      repeat (12) begin
        @(posedge clk);
        #1;
        chk({leg_acc, m_valid}, 2'h0);
      end
      @(posedge clk);
      leg_req <= 1'b0;
    end
    @(posedge clk);
    leg_pend <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({msi_on, msix_on, granted, flags, leg_acc, msi_acc, m_valid, c_done}, 64'h0);
    rd({8'h00, eic_pkg::DW_MSI_CTRL}, 32'h0086_0005);
    cfg(1'b1, {8'h00, eic_pkg::DW_MSI_DATA}, 32'h0000_ABC0, 4'hF);
    cfg(1'b1, {8'h01, eic_pkg::DW_MSI_DATA}, 32'h0000_1234, 4'hF);
    cfg(1'b1, {8'h00, eic_pkg::DW_MSI_DATA}, 32'h0000_55FF, 4'h1);
    rd({8'h00, eic_pkg::DW_MSI_DATA}, 32'h0000_ABFF);
    rd({8'h01, eic_pkg::DW_MSI_DATA}, 32'h0000_0000);
    cfg(1'b1, {8'h00, eic_pkg::DW_MSI_CTRL}, 32'hFFFF_FFFF, 4'hF);
    rd({8'h00, eic_pkg::DW_MSI_CTRL}, 32'h0086_0005);
    cfg(1'b1, {8'h00, eic_pkg::DW_CMD_STATUS}, 32'h0000_0407, 4'hF);
    rd({8'h00, eic_pkg::DW_CMD_STATUS}, 32'h0000_0007);
    t1_ovr <= 1'b1;
    cfg(1'b1, {8'h00, eic_pkg::DW_T1_IO_BASE}, 32'h0000_FFFF, 4'hF);
    t1_ovr <= 1'b0;
    rd({8'h00, eic_pkg::DW_T1_IO_BASE}, 32'h0000_0000);
    slow <= 1'b1;
    legacy(1'b1);
    rc(eic_pkg::DW_CMD_STATUS, 32'h0000_0400, 4'h2);
    chk(flags[0], 1'b1);
    legacy(1'b0);
    rc(eic_pkg::DW_CMD_STATUS, 32'h0000_0000, 4'h2);
    rc(eic_pkg::DW_MSI_ADDR_LO, 32'h1000_0004, 4'hF);
    rc(eic_pkg::DW_MSI_CTRL, 32'h0051_0000, 4'h4);
    chk({msi_on, granted}, {1'b1, 3'h3});
    rd({8'h00, eic_pkg::DW_MSI_MASK}, 32'h0000_0000);
    msi(5'h12, eic_pkg::EIC_MSG_MWR32, 64'h0000_0000_1000_0004, 32'h0000_ABFA);
    legacy(1'b0);
    rc(eic_pkg::DW_MSI_ADDR_HI, 32'h0000_0001, 4'hF);
    msi(5'h05, eic_pkg::EIC_MSG_MWR64, 64'h0000_0001_1000_0004, 32'h0000_ABFD);
    rc(eic_pkg::DW_MSIX_CTRL, 32'h8000_0000, 4'h8);
    chk(msix_on, 1'b1);
    msi(5'h00, eic_pkg::EIC_MSG_MWR64, 64'h0000_0001_1000_0004, 32'h0000_ABF8);
    rc(eic_pkg::DW_MSI_CTRL, 32'h0000_0000, 4'h4);
    legacy(1'b0);
    results();
  end
endmodule
`default_nettype wire
